/* File: flash_seq_pkg.sv */
// Shared constants and carrier types for the serial flash command sequencer
package flash_seq_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int SUS_LAT_NS = 20000;
    localparam int SUS_LAT_CYC = SUS_LAT_NS / CLK_PERIOD_NS;
    localparam int RESUME_NS = 200;
    localparam int RESUME_CYC = RESUME_NS / CLK_PERIOD_NS;

    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_READ_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OP_READ_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OP_READ_DUAL_IO = 8'hBB;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_STATUS_WR_1 = 8'h01;
    localparam logic [7:0] OP_STATUS_WR_2 = 8'h31;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_SECURITY_ERASE = 8'h44;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
    localparam logic [7:0] OP_SECURITY_PROGRAM = 8'h42;

    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [5:0] OPCODE_CLOCKS = 6'h08;
    localparam logic [5:0] ADDR_CLOCKS_SINGLE = 6'h18;
    localparam logic [5:0] ADDR_CLOCKS_DUAL = 6'h0C;
    localparam logic [5:0] DUMMY_CLOCKS_FAST = 6'h08;
    localparam logic [5:0] MODE_CLOCKS_DUAL_IO = 6'h04;
    localparam int FIFO_DEPTH = 16;
    localparam int SECTOR_W = 12;

    // Busy, write enable latch and suspend flags as seen by status reads
    typedef struct packed {
        logic suspend_flag;
        logic write_enable_latch;
        logic busy;
    } status_s;

    // Block protection setting
    typedef struct packed {
        logic protect_sector_granular;
        logic protect_top_bottom;
        logic protect_level_bit2;
        logic protect_level_bit1;
        logic protect_level_bit0;
    } protect_s;

    typedef enum logic [2:0] {
        PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA, PH_TAIL, PH_IGNORE
    } phase_e;

    typedef enum logic [2:0] {
        BG_IDLE, BG_CHIP, BG_RUN, BG_SUSPENDING, BG_SUSPENDED
    } bg_e;

endpackage : flash_seq_pkg

/* File: flash_seq.sv */
// Serial flash command sequencer: erase, suspend/resume and read family
`timescale 1ns/10ps

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (clear) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule : byte_fifo

// Notes on behaviour
// - Chip erase writes FFh everywhere; needs latch
// - Opcode C7h/60h, exactly eight clocks, else dropped
// - Busy during chip erase; end clears busy, latch
// - Any protected page blocks chip erase
// - Suspend 75h only for running program/erase
// - Suspend ignored during chip erase
// - Erase suspend refuses status writes, erases
// - Program suspend refuses status writes, programs
// - Other regions allowed; suspended sector refused
// - Suspend flag at once; busy drops after latency
// - Reset leaves suspend state, flag zero
// - Resume 7Ah only when suspended, not busy
// - Resume clears flag at once, busy promptly
// - Read 03h: sample rising, shift falling, MSB
// - Address increments per byte until deselect
// - Reads while busy ignored, no disturbance
// - Fast read adds eight ignored dummy clocks
// - 3Bh sends two bits per clock
// - 6Bh needs quad enable; four bits per clock
// - BBh takes address two bits per clock
module flash_seq #(
    parameter logic [31:0] ARRAY_BYTES = 32'h0100_0000,
    parameter logic [31:0] OP_CYCLES = 32'h0000_9C40
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic quad_enable_bit,
    input wire flash_seq_pkg::protect_s protect,
    input wire logic wel_set,
    input wire logic op_start,
    input wire logic op_program,
    input wire logic [flash_seq_pkg::SECTOR_W-1:0] op_sector,
    output logic op_done,
    input wire logic [7:0] req_opcode,
    input wire logic [flash_seq_pkg::SECTOR_W-1:0] req_sector,
    output logic req_allowed,
    output flash_seq_pkg::status_s status,
    output logic [23:0] mem_rd_addr,
    output logic mem_rd_en,
    input wire logic [7:0] mem_rd_data,
    output logic [23:0] mem_wr_addr,
    output logic mem_wr_en,
    output logic [7:0] mem_wr_data
);
    function automatic logic is_read(input logic [7:0] op);
        return op == flash_seq_pkg::OP_READ || op == flash_seq_pkg::OP_FAST_READ ||
               op == flash_seq_pkg::OP_READ_DUAL_OUT || op == flash_seq_pkg::OP_READ_QUAD_OUT ||
               op == flash_seq_pkg::OP_READ_DUAL_IO;
    endfunction : is_read

    function automatic logic is_erase(input logic [7:0] op);
        return op == flash_seq_pkg::OP_SECTOR_ERASE || op == flash_seq_pkg::OP_HALF_BLOCK_ERASE ||
               op == flash_seq_pkg::OP_BLOCK_ERASE || op == flash_seq_pkg::OP_CHIP_ERASE_A ||
               op == flash_seq_pkg::OP_CHIP_ERASE_B || op == flash_seq_pkg::OP_SECURITY_ERASE;
    endfunction : is_erase

    // Two flops on cs_n, sclk and every io pin before any logic reads them
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic cs_prev_reg;
    logic sclk_prev_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 6'h01;
            sync2_reg <= 6'h01;
            cs_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {io_in, sclk, cs_n};
            sync2_reg <= sync1_reg;
            cs_prev_reg <= sync2_reg[0];
            sclk_prev_reg <= sync2_reg[1];
        end
    end

    wire cs_s = sync2_reg[0];
    wire [3:0] io_s = sync2_reg[5:2];
    wire cs_rise = cs_s && !cs_prev_reg;
    wire sck_rise = !cs_s && sync2_reg[1] && !sclk_prev_reg;
    wire sck_fall = !cs_s && !sync2_reg[1] && sclk_prev_reg;

    flash_seq_pkg::phase_e phase_reg;
    logic [5:0] cnt_reg;
    logic [7:0] opcode_reg;
    logic [23:0] addr_reg;
    logic extra_reg;
    logic [7:0] byte_reg;
    logic [2:0] grp_reg;
    logic [3:0] io_out_reg;
    logic fetch_run_reg;
    logic [23:0] fetch_addr_reg;
    logic rd_pend_reg;
    flash_seq_pkg::bg_e bg_reg;
    logic [31:0] bg_cnt_reg;
    logic [31:0] sus_cnt_reg;
    logic sus_reg;
    logic wel_reg;
    logic erase_kind_reg;
    logic [flash_seq_pkg::SECTOR_W-1:0] sector_reg;

    wire busy = bg_reg == flash_seq_pkg::BG_CHIP || bg_reg == flash_seq_pkg::BG_RUN ||
                bg_reg == flash_seq_pkg::BG_SUSPENDING;
    wire [7:0] opcode_next = {opcode_reg[6:0], io_s[0]};
    wire dual_addr = opcode_reg == flash_seq_pkg::OP_READ_DUAL_IO;
    // Upper line holds the higher address bit
    wire [23:0] addr_next = dual_addr ? {addr_reg[21:0], io_s[1], io_s[0]}
                                      : {addr_reg[22:0], io_s[0]};
    wire [5:0] addr_clocks = dual_addr ? flash_seq_pkg::ADDR_CLOCKS_DUAL
                                       : flash_seq_pkg::ADDR_CLOCKS_SINGLE;
    // 0Bh, 3Bh and 6Bh share eight dummy clocks; BBh has mode clocks
    wire [5:0] dummy_clocks = opcode_reg == flash_seq_pkg::OP_READ ? 6'h00 :
                              dual_addr ? flash_seq_pkg::MODE_CLOCKS_DUAL_IO
                                        : flash_seq_pkg::DUMMY_CLOCKS_FAST;
    wire [1:0] lane_sel = opcode_reg == flash_seq_pkg::OP_READ_QUAD_OUT ? 2'h2 :
                          (opcode_reg == flash_seq_pkg::OP_READ_DUAL_OUT || dual_addr) ? 2'h1
                                                                                      : 2'h0;
    // Read refused while busy, or 6Bh while quad not enabled
    wire read_refused = busy ||
        (opcode_next == flash_seq_pkg::OP_READ_QUAD_OUT && !quad_enable_bit);
    wire addr_last = phase_reg == flash_seq_pkg::PH_ADDR && cnt_reg == addr_clocks - 6'h01;
    wire start_fetch = sck_rise && addr_last;

    // Command needs exactly eight clocks before deselect
    wire cmd_exact = cs_rise && phase_reg == flash_seq_pkg::PH_TAIL && !extra_reg;
    wire is_chip_op = opcode_reg == flash_seq_pkg::OP_CHIP_ERASE_A ||
                      opcode_reg == flash_seq_pkg::OP_CHIP_ERASE_B;
    wire any_protected = protect.protect_level_bit2 || protect.protect_level_bit1 ||
                         protect.protect_level_bit0;
    // Latch set, nothing protected, not busy, not suspended
    wire chip_go = cmd_exact && is_chip_op && wel_reg && !any_protected && !busy && !sus_reg;
    // Only a running sector/block erase or program suspends
    wire susp_go = cmd_exact && opcode_reg == flash_seq_pkg::OP_SUSPEND &&
                   bg_reg == flash_seq_pkg::BG_RUN && !sus_reg;
    wire resume_go = cmd_exact && opcode_reg == flash_seq_pkg::OP_RESUME &&
                     sus_reg && !busy;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= flash_seq_pkg::PH_OPCODE;
            cnt_reg <= '0;
            opcode_reg <= '0;
            addr_reg <= '0;
            extra_reg <= 1'b0;
        end else if (cs_s) begin
            phase_reg <= flash_seq_pkg::PH_OPCODE;
            cnt_reg <= '0;
            extra_reg <= 1'b0;
        end else if (sck_rise) begin
            cnt_reg <= cnt_reg + 6'h01;
            unique case (phase_reg)
                flash_seq_pkg::PH_OPCODE: begin
                    opcode_reg <= opcode_next;
                    if (cnt_reg == flash_seq_pkg::OPCODE_CLOCKS - 6'h01) begin
                        cnt_reg <= '0;
                        if (!is_read(opcode_next)) phase_reg <= flash_seq_pkg::PH_TAIL;
                        else if (read_refused) phase_reg <= flash_seq_pkg::PH_IGNORE;
                        else phase_reg <= flash_seq_pkg::PH_ADDR;
                    end
                end
                flash_seq_pkg::PH_ADDR: begin
                    addr_reg <= addr_next;
                    if (addr_last) begin
                        cnt_reg <= '0;
                        phase_reg <= dummy_clocks == 6'h00 ? flash_seq_pkg::PH_DATA
                                                           : flash_seq_pkg::PH_DUMMY;
                    end
                end
                flash_seq_pkg::PH_DUMMY: begin
                    // Input lines not looked at here
                    if (cnt_reg == dummy_clocks - 6'h01) phase_reg <= flash_seq_pkg::PH_DATA;
                end
                flash_seq_pkg::PH_TAIL: extra_reg <= 1'b1;
                flash_seq_pkg::PH_DATA, flash_seq_pkg::PH_IGNORE: cnt_reg <= cnt_reg;
                default: phase_reg <= flash_seq_pkg::PH_IGNORE;
            endcase
        end
    end

    // Prefetch into the FIFO; a full FIFO stalls the fetcher
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    wire data_fall = sck_fall && phase_reg == flash_seq_pkg::PH_DATA;
    wire pop = data_fall && grp_reg == 3'h0;
    wire issue = fetch_run_reg && !rd_pend_reg && fifo_in_ready && !start_fetch;

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(flash_seq_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .clear(cs_s),
        .in_valid(rd_pend_reg),
        .in_ready(fifo_in_ready),
        .in_data(mem_rd_data),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fetch_run_reg <= 1'b0;
            fetch_addr_reg <= '0;
            rd_pend_reg <= 1'b0;
        end else if (cs_s) begin
            fetch_run_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
        end else begin
            rd_pend_reg <= issue;
            if (start_fetch) begin
                fetch_run_reg <= 1'b1;
                fetch_addr_reg <= addr_next;
            end else if (issue) begin
                fetch_addr_reg <= fetch_addr_reg + 24'h000001;
            end
        end
    end

    assign mem_rd_en = issue;
    assign mem_rd_addr = fetch_addr_reg;

    // Output shifter: one group per falling edge, MSB first
    wire [7:0] load_byte = fifo_out_valid ? fifo_out_data : flash_seq_pkg::ERASED_BYTE;
    wire [7:0] cur_byte = pop ? load_byte : byte_reg;
    wire [3:0] group = lane_sel == 2'h2 ? cur_byte[7:4] :
                       lane_sel == 2'h1 ? {2'h0, cur_byte[7:6]} : {2'h0, cur_byte[7], 1'b0};
    wire [7:0] shifted = lane_sel == 2'h2 ? {cur_byte[3:0], 4'h0} :
                         lane_sel == 2'h1 ? {cur_byte[5:0], 2'h0} : {cur_byte[6:0], 1'b0};
    wire [2:0] grp_count = lane_sel == 2'h2 ? 3'h1 : lane_sel == 2'h1 ? 3'h3 : 3'h7;
    wire [2:0] grp_after = pop ? grp_count : grp_reg - 3'h1;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byte_reg <= '0;
            grp_reg <= '0;
            io_out_reg <= '0;
        end else if (cs_s) begin
            grp_reg <= '0;
        end else if (data_fall) begin
            byte_reg <= shifted;
            io_out_reg <= group;
            grp_reg <= grp_after;
        end
    end

    // Lines driven only in the data phase, after host turnaround
    wire in_data = phase_reg == flash_seq_pkg::PH_DATA && !cs_s;
    assign io_out = io_out_reg;
    assign io_oe = !in_data ? 4'h0 :
                   lane_sel == 2'h2 ? 4'hF :
                   lane_sel == 2'h1 ? 4'h3 : 4'h2;

    // Background operation engine
    wire bg_finish = (bg_reg == flash_seq_pkg::BG_CHIP && bg_cnt_reg == ARRAY_BYTES - 32'h1) ||
                     (bg_reg == flash_seq_pkg::BG_RUN && bg_cnt_reg == OP_CYCLES - 32'h1);
    wire ext_go = op_start && bg_reg == flash_seq_pkg::BG_IDLE && !sus_reg && !chip_go;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bg_reg <= flash_seq_pkg::BG_IDLE;
            bg_cnt_reg <= '0;
            sus_cnt_reg <= '0;
            erase_kind_reg <= 1'b0;
            sector_reg <= '0;
        end else begin
            unique case (bg_reg)
                flash_seq_pkg::BG_IDLE: begin
                    bg_cnt_reg <= '0;
                    if (chip_go) bg_reg <= flash_seq_pkg::BG_CHIP;
                    else if (ext_go) begin
                        bg_reg <= flash_seq_pkg::BG_RUN;
                        erase_kind_reg <= !op_program;
                        sector_reg <= op_sector;
                    end
                end
                flash_seq_pkg::BG_CHIP: begin
                    // Suspend never touches this state
                    bg_cnt_reg <= bg_cnt_reg + 32'h1;
                    if (bg_finish) bg_reg <= flash_seq_pkg::BG_IDLE;
                end
                flash_seq_pkg::BG_RUN: begin
                    bg_cnt_reg <= bg_cnt_reg + 32'h1;
                    sus_cnt_reg <= '0;
                    if (bg_finish) bg_reg <= flash_seq_pkg::BG_IDLE;
                    else if (susp_go) bg_reg <= flash_seq_pkg::BG_SUSPENDING;
                end
                flash_seq_pkg::BG_SUSPENDING: begin
                    // Progress held; busy drops when latency ends
                    sus_cnt_reg <= sus_cnt_reg + 32'h1;
                    if (sus_cnt_reg == 32'(flash_seq_pkg::SUS_LAT_CYC) - 32'h1) begin
                        bg_reg <= flash_seq_pkg::BG_SUSPENDED;
                    end
                end
                flash_seq_pkg::BG_SUSPENDED: begin
                    // Busy back well inside the resume window
                    if (resume_go) bg_reg <= flash_seq_pkg::BG_RUN;
                end
                default: bg_reg <= flash_seq_pkg::BG_IDLE;
            endcase
        end
    end

    // Flags: hardware set wins over a same-cycle clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sus_reg <= 1'b0;
            wel_reg <= 1'b0;
        end else begin
            if (susp_go) sus_reg <= 1'b1;
            else if (resume_go) sus_reg <= 1'b0;
            if (wel_set) wel_reg <= 1'b1;
            else if (bg_finish) wel_reg <= 1'b0;
        end
    end

    // Erase walk writes the erased value to every byte
    assign mem_wr_en = bg_reg == flash_seq_pkg::BG_CHIP;
    assign mem_wr_addr = bg_cnt_reg[23:0];
    assign mem_wr_data = flash_seq_pkg::ERASED_BYTE;
    assign op_done = bg_finish && bg_reg == flash_seq_pkg::BG_RUN;

    // Gate for commands handled elsewhere while suspended
    wire req_status = req_opcode == flash_seq_pkg::OP_STATUS_WR_1 ||
                      req_opcode == flash_seq_pkg::OP_STATUS_WR_2;
    wire req_prog = req_opcode == flash_seq_pkg::OP_PAGE_PROGRAM ||
                    req_opcode == flash_seq_pkg::OP_QUAD_PROGRAM ||
                    req_opcode == flash_seq_pkg::OP_SECURITY_PROGRAM;
    wire req_erase = is_erase(req_opcode);
    wire erase_susp = sus_reg && erase_kind_reg;
    wire prog_susp = sus_reg && !erase_kind_reg;
    assign req_allowed = !(erase_susp && (req_status || req_erase)) &&
                         !(prog_susp && (req_status || req_prog)) &&
                         !(sus_reg && (req_prog || req_erase) && req_sector == sector_reg);

    assign status = {sus_reg, wel_reg, busy};
endmodule : flash_seq

/* File: flash_seq_sva.sv */
// Port assertions for the flash command sequencer
`timescale 1ns/10ps
module flash_seq_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] io_oe,
    input wire logic quad_enable_bit,
    input wire flash_seq_pkg::protect_s protect,
    input wire logic [7:0] req_opcode,
    input wire logic req_allowed,
    input wire flash_seq_pkg::status_s status,
    input wire logic mem_wr_en,
    input wire logic [7:0] mem_wr_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [11:0] sus_cnt_reg;
    // Latency too long for a delay range
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) sus_cnt_reg <= 12'h000;
        else sus_cnt_reg <= (status.suspend_flag && status.busy) ? sus_cnt_reg + 12'h001 : 12'h000;
    end
    property p_erase_data;
        mem_wr_en |-> mem_wr_data == 8'hFF && status.busy && !status.suspend_flag;
    endproperty
    a_erase_data: assert property (p_erase_data) else $error("erase write bad");
    property p_erase_end;
        $fell(mem_wr_en) |-> ##[0:2] (!status.busy && !status.write_enable_latch);
    endproperty
    a_erase_end: assert property (p_erase_end) else $error("erase end flags");
    property p_erase_gate;
        $rose(mem_wr_en) |-> protect[2:0] == 3'h0 && status.write_enable_latch;
    endproperty
    a_erase_gate: assert property (p_erase_gate) else $error("erase gate");
    property p_sus_lat;
        sus_cnt_reg <= 12'h834;
    endproperty
    a_sus_lat: assert property (p_sus_lat) else $error("suspend latency");
    property p_sus_set;
        $rose(status.suspend_flag) |-> $past(status.busy) && !mem_wr_en;
    endproperty
    a_sus_set: assert property (p_sus_set) else $error("suspend accept");
    property p_resume;
        $fell(status.suspend_flag) |-> status.busy && !$past(status.busy);
    endproperty
    a_resume: assert property (p_resume) else $error("resume flags");
    property p_quad;
        io_oe == 4'hF |-> quad_enable_bit;
    endproperty
    a_quad: assert property (p_quad) else $error("quad without enable");
    property p_busy_read;
        io_oe != 4'h0 |-> !status.busy;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("read while busy");
    property p_sw_refuse;
        status.suspend_flag && (req_opcode == 8'h01 || req_opcode == 8'h31) |-> !req_allowed;
    endproperty
    a_sw_refuse: assert property (p_sw_refuse) else $error("status write allowed");
endmodule : flash_seq_sva
bind flash_seq flash_seq_sva u_sva (.clk(clk), .nrst(nrst), .io_oe(io_oe),
    .quad_enable_bit(quad_enable_bit), .protect(protect), .req_opcode(req_opcode),
    .req_allowed(req_allowed), .status(status), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data));

/* File: spi_host.sv */
// SPI host model: chip select, mode 0 serial clock, data lines
`timescale 1ns/10ps
module spi_host (
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io_drv,
    input wire logic [3:0] io_line
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io_drv = 4'h0;
    end
    // Highest line carries the higher bit; changes only while sclk low
    task automatic send(input logic [23:0] v, input int n, input int w);
        for (int i = n - w; i >= 0; i -= w) begin
            io_drv = 4'(v >> i) & 4'((1 << w) - 1);
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
    endtask : send
    // Released lines toggle so no stale value passes for data
    task automatic recv(input int w, output logic [15:0] q);
        q = 16'h0000;
        for (int i = 0; i < 16 / w; i++) begin
            io_drv = ~io_drv;
            #62.5 sclk = 1'b1;
            q = (w == 1) ? {q[14:0], io_line[1]} : (w == 2) ? {q[13:0], io_line[1:0]} : {q[11:0], io_line};
            #62.5 sclk = 1'b0;
        end
    endtask : recv
    task automatic read(input logic [7:0] op, input logic [23:0] a, input int aw, input int dum,
                        input int w, output logic [15:0] q);
        #62.5 cs_n = 1'b0;
        send(24'(op), 8, 1);
        send(a, 24, aw);
        send(24'h00005A, dum, 1);
        recv(w, q);
        #62.5 cs_n = 1'b1;
        #500;
    endtask : read
    // Deselect right after the last bit
    task automatic cmd(input logic [7:0] op, input int n);
        #62.5 cs_n = 1'b0;
        send(24'(op), n, 1);
        #62.5 cs_n = 1'b1;
        #500;
    endtask : cmd
endmodule : spi_host

/* File: tb_serial_flash_erase_suspend_read.sv */
// Self-checking bench for the flash command sequencer
`timescale 1ns/10ps
module tb_serial_flash_erase_suspend_read;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n, sclk, op_done, req_allowed, mem_rd_en, mem_wr_en;
    logic qe = 1'b1, wel_set = 1'b0, op_start = 1'b0, op_program = 1'b0;
    logic [3:0] io_drv, io_out, io_oe, io_line;
    flash_seq_pkg::protect_s protect = 5'h00;
    flash_seq_pkg::status_s status;
    logic [11:0] op_sector = 12'h005, req_sector = 12'h005;
    logic [7:0] req_opcode = 8'h00, mem_rd_data = 8'h00, mem_wr_data;
    logic [23:0] mem_rd_addr, mem_wr_addr;
    logic [15:0] q;
    int bad_count = 0, compares = 0, wr_count = 0, done_count = 0;
    always #5 clk = ~clk;
    assign io_line = (io_oe & io_out) | (~io_oe & io_drv);
    always @(posedge clk) begin
        mem_rd_data <= mem_rd_en ? mem_rd_addr[7:0] ^ 8'hA5 : ~mem_rd_data;
        if (mem_wr_en && mem_wr_addr == 24'(wr_count)) wr_count <= wr_count + 1;
        if (op_done) done_count <= done_count + 1;
    end
    flash_seq #(.ARRAY_BYTES(32'h0000_0400), .OP_CYCLES(32'h0000_0400)) DUT (
        .clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .io_in(io_line), .io_out(io_out),
        .io_oe(io_oe), .quad_enable_bit(qe), .protect(protect), .wel_set(wel_set),
        .op_start(op_start), .op_program(op_program), .op_sector(op_sector), .op_done(op_done),
        .req_opcode(req_opcode), .req_sector(req_sector), .req_allowed(req_allowed),
        .status(status), .mem_rd_addr(mem_rd_addr), .mem_rd_en(mem_rd_en),
        .mem_rd_data(mem_rd_data), .mem_wr_addr(mem_wr_addr), .mem_wr_en(mem_wr_en),
        .mem_wr_data(mem_wr_data));
    spi_host host (.cs_n(cs_n), .sclk(sclk), .io_drv(io_drv), .io_line(io_line));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic wait_busy(input logic v, input int lim);
        for (int i = 0; i < lim && status.busy !== v; i++) @(negedge clk);
        if (status.busy !== v) begin
            bad_count++;
            conclude();
        end
    endtask : wait_busy
    task automatic req(input logic [7:0] op, input logic [11:0] s, input logic e);
        @(negedge clk) req_opcode = op;
        req_sector = s;
        #1 chk(16'(req_allowed), 16'(e));
    endtask : req
    task automatic pulse_op();
        @(negedge clk) op_start = 1'b1;
        @(negedge clk) op_start = 1'b0;
    endtask : pulse_op
    task automatic t_idle();
        host.cmd(8'h75, 8);
        chk(16'(status), 16'h0000);
        host.cmd(8'h7A, 8);
        chk(16'(status), 16'h0000);
    endtask : t_idle
    task automatic t_reads();
        logic [7:0] ops [5] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB};
        int dum [5] = '{0, 8, 8, 8, 4};
        int w [5] = '{1, 1, 2, 4, 2};
        logic [7:0] lo;
        for (int i = 0; i < 5; i++) begin
            lo = 8'hFB + 8'(i);
            host.read(ops[i], {16'h0012, lo}, (i == 4) ? 2 : 1, dum[i], w[i], q);
            chk(q, {lo ^ 8'hA5, (lo + 8'h01) ^ 8'hA5});
        end
        @(negedge clk) qe = 1'b0;
        host.read(8'h6B, 24'h000000, 1, 8, 4, q);
        chk(q, 16'hF0F0);
        @(negedge clk) qe = 1'b1;
    endtask : t_reads
    task automatic t_erase();
        @(negedge clk) wel_set = 1'b1;
        @(negedge clk) wel_set = 1'b0;
        host.cmd(8'hC7, 7);
        chk(16'(status), 16'h0002);
        @(negedge clk) protect = 5'h04;
        host.cmd(8'hC7, 8);
        chk(16'(status), 16'h0002);
        @(negedge clk) protect = 5'h00;
        host.cmd(8'h60, 8);
        chk(16'(status), 16'h0003);
        host.cmd(8'h75, 8);
        chk(16'(status), 16'h0003);
        wait_busy(1'b0, 2000);
        chk(16'(wr_count), 16'h0400);
        chk(16'(status), 16'h0000);
    endtask : t_erase
    task automatic t_suspend(input logic p);
        logic [7:0] ers [6] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h44};
        logic [7:0] prg [3] = '{8'h02, 8'h32, 8'h42};
        @(negedge clk) op_program = p;
        pulse_op();
        host.read(8'h03, 24'h000010, 1, 0, 1, q);
        chk(16'(status), 16'h0001);
        host.cmd(8'h75, 8);
        chk(16'(status.suspend_flag), 16'h0001);
        wait_busy(1'b0, 2100);
        host.read(8'h03, 24'h000020, 1, 0, 1, q);
        chk(q, 16'h8584);
        req(8'h01, 12'h006, 1'b0);
        req(8'h31, 12'h006, 1'b0);
        for (int i = 0; i < 6; i++) req(p ? prg[i % 3] : ers[i], 12'h006, 1'b0);
        req(p ? 8'h20 : 8'h02, 12'h006, 1'b1);
        req(p ? 8'h20 : 8'h02, 12'h005, 1'b0);
        host.cmd(8'h7A, 8);
        chk(16'(status), 16'h0001);
        wait_busy(1'b0, 1200);
        chk(16'(done_count), 16'(p) + 16'h0001);
        #(flash_seq_pkg::SUS_LAT_NS);
    endtask : t_suspend
    task automatic t_reset();
        pulse_op();
        host.cmd(8'h75, 8);
        @(negedge clk) nrst = 1'b0;
        @(negedge clk) nrst = 1'b1;
        chk(16'(status), 16'h0000);
    endtask : t_reset
    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        repeat (5) @(negedge clk);
        t_idle();
        t_reads();
        t_erase();
        t_suspend(1'b0);
        t_suspend(1'b1);
        t_reset();
        conclude();
    end
endmodule : tb_serial_flash_erase_suspend_read
